// ==== shared/sfp_defines.svh ====
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
// Function
// RULE_01: Array holds 2048 pages of 264 bytes.
// RULE_02: Write protect low blocks programming pages 0-255.
// RULE_03: Two 264-byte buffers, writable while busy.
// RULE_04: Buffer load changes only bytes written.
// RULE_05: Buffers hold data without refresh.
// RULE_06: Master clocks data; programming is self-timed.
// RULE_07: Select low selects; high means quiescent.
// RULE_08: Deselected: ignore input, output released.
// RULE_09: Deselect edge launches internal sequences.
// RULE_10: Transfers are 8-bit words.
// RULE_11: Works with SPI mode 0 or 3.
// RULE_12: Ready/busy pin reports internal activity.
// RULE_13: Sample on rising, shift out on falling.
// RULE_14: Reset aborts operation, engine returns idle.
// RULE_15: Reset leaves buffer contents intact.
// RULE_16: Serial clock up to about 10 MHz.

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define SFP_PAGES        2048
`define SFP_PAGE_BYTES   264
`define SFP_PROT_PAGES   256
`define SFP_WORD_BITS    8

// ----------------------------------------------------------------
// Address word: 24 bits, page then byte
// ----------------------------------------------------------------
`define SFP_PAGE_LSB     9
`define SFP_BYTE_MSB     8

// ----------------------------------------------------------------
// Opcodes: high nibble selects the command, bit 0 the buffer
// ----------------------------------------------------------------
`define SFP_OP_KIND_MASK 8'hf0
`define SFP_OP_BUF_WRITE 8'h10
`define SFP_OP_BUF_READ  8'h20
`define SFP_OP_PROGRAM   8'h30
`define SFP_OP_FETCH     8'h40
`define SFP_OP_STATUS    8'h50

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define SFP_ST_READY     7
`define SFP_ST_REFUSED   6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFP_CLK_PERIOD_NS 25
`define SFP_PROG_TIME_NS  20000

`endif

// ==== shared/sfp_pkg.sv ====
package sfp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_WAIT} engine_e;
  typedef enum logic {JOB_PROGRAM, JOB_FETCH} job_e;
endpackage

// ==== design/page_buffer.sv ====
`timescale 1ns/1ps
module page_buffer #(
  parameter int DEPTH = 264,
  parameter int AW    = 9
) (
  input  wire logic          sys_clk,  // System clock
  input  wire logic          s_we,     // Serial side write strobe
  input  wire logic [AW-1:0] s_addr,   // Serial side byte address
  input  wire logic [7:0]    s_wdata,  // Serial side write data
  output logic      [7:0]    s_rdata,  // Serial side read data
  input  wire logic          i_we,     // Engine side write strobe
  input  wire logic [AW-1:0] i_addr,   // Engine side byte address
  input  wire logic [7:0]    i_wdata,  // Engine side write data
  output logic      [7:0]    i_rdata   // Engine side read data
);

  logic [7:0] mem [DEPTH];

  // No reset on purpose: contents survive a device reset
  always_ff @(posedge sys_clk) begin  // see RULE_05 RULE_15
    if (s_we) begin
      mem[s_addr] <= s_wdata;  // see RULE_04
    end
    if (i_we && !(s_we && s_addr == i_addr)) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign s_rdata = mem[s_addr];
  assign i_rdata = mem[i_addr];

endmodule

// ==== design/serial_paged_flash_port.sv ====
`timescale 1ns/1ps
`include "sfp_defines.svh"
module serial_paged_flash_port #(
  parameter int PAGES       = `SFP_PAGES,
  parameter int PAGE_BYTES  = `SFP_PAGE_BYTES,
  parameter int PROT_PAGES  = `SFP_PROT_PAGES,
  parameter int PROG_CYCLES = (`SFP_PROG_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS
) (
  input  wire logic sys_clk,          // System clock, 40 MHz
  input  wire logic resetn,           // Async reset pin, active low
  input  wire logic serial_clock,     // Serial clock from master
  input  wire logic device_select_n,  // Device select, active low
  input  wire logic serial_in,        // Serial data in
  input  wire logic write_protect_n,  // Write protect, active low
  output logic      serial_out,       // Serial data out
  output logic      serial_out_oe,    // High while serial_out is driven
  output logic      ready_busy_flag   // High when ready, low when busy
);

  localparam int PW = $clog2(PAGES);
  localparam int BW = $clog2(PAGE_BYTES);
  localparam int FW = $clog2(PAGES * PAGE_BYTES);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [BW-1:0] LAST_BYTE = BW'(PAGE_BYTES - 1);
  localparam logic [PW-1:0] PROT_TOP  = PW'(PROT_PAGES);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       sck_d;
  logic       cs_n_d;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 4'hf;
      pin_sync <= 4'hf;
      sck_d    <= 1'b1;
      cs_n_d   <= 1'b1;
    end else begin
      pin_meta <= {serial_clock, device_select_n, serial_in, write_protect_n};
      pin_sync <= pin_meta;
      sck_d    <= pin_sync[3];
      cs_n_d   <= pin_sync[2];
    end
  end

  wire sck_s    = pin_sync[3];
  wire cs_n_s   = pin_sync[2];
  wire si_s     = pin_sync[1];
  wire wp_n_s   = pin_sync[0];
  wire selected = !cs_n_s;                              // see RULE_07
  // Four samples per bit at 10 MHz keep both edges visible
  wire sck_rise = selected && sck_s && !sck_d;          // see RULE_13 RULE_16
  wire sck_fall = selected && !sck_s && sck_d;          // see RULE_11 RULE_13
  wire cs_rise  = cs_n_s && !cs_n_d;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  logic [2:0]    bit_cnt;
  logic [6:0]    rx;
  logic [2:0]    byte_idx;
  logic [7:0]    opcode;
  logic [23:0]   addr;
  logic [BW-1:0] ptr;
  logic [7:0]    tx;
  logic          tx_loaded;
  logic          out_phase;
  logic          refused;

  wire           rx_done    = sck_rise && bit_cnt == 3'h7;  // see RULE_10
  wire [7:0]     rx_byte    = {rx, si_s};
  wire [7:0]     cmd_now    = (byte_idx == 3'h0) ? rx_byte : opcode;
  wire [7:0]     cmd_kind   = cmd_now & `SFP_OP_KIND_MASK;
  wire           buf_sel    = cmd_now[0];
  wire           is_write   = cmd_kind == `SFP_OP_BUF_WRITE;
  wire           is_read    = cmd_kind == `SFP_OP_BUF_READ;
  wire           is_status  = cmd_kind == `SFP_OP_STATUS;
  wire           data_phase = byte_idx == 3'h4;
  wire [23:0]    addr_next  = {addr[15:0], rx_byte};
  wire [BW-1:0]  byte_req   = addr_next[`SFP_BYTE_MSB:0];
  wire [BW-1:0]  ptr_start  = (byte_req > LAST_BYTE) ? '0 : byte_req;
  wire [BW-1:0]  s_addr     = (byte_idx == 3'h3) ? ptr_start : ptr;
  wire [BW-1:0]  s_addr_inc = (s_addr == LAST_BYTE) ? '0 : BW'(s_addr + 1'b1);
  wire           s_write    = rx_done && data_phase && is_write;   // see RULE_04
  wire           load_tx    = rx_done && (is_status || (is_read && byte_idx >= 3'h3));
  wire [7:0]     status_byte;

  logic [7:0]    s_rd [2];
  logic [7:0]    i_rd [2];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt  <= 3'h0;
      rx       <= 7'h00;
      byte_idx <= 3'h0;
      opcode   <= 8'h00;
      addr     <= 24'h000000;
      ptr      <= '0;
    end else if (!selected) begin
      bit_cnt  <= 3'h0;                                 // see RULE_08
      byte_idx <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx      <= rx_byte[6:0];
      if (rx_done) begin
        if (byte_idx != 3'h4) begin
          byte_idx <= byte_idx + 3'h1;
        end
        if (byte_idx == 3'h0) begin
          opcode <= rx_byte;
        end else if (byte_idx != 3'h4) begin
          addr <= addr_next;
        end
        if (byte_idx >= 3'h3) begin
          ptr <= (is_read || data_phase) ? s_addr_inc : s_addr;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx         <= 8'h00;
      tx_loaded  <= 1'b0;
      out_phase  <= 1'b0;
      serial_out <= 1'b0;
    end else if (!selected) begin
      tx_loaded <= 1'b0;
      out_phase <= 1'b0;
    end else if (load_tx) begin
      tx        <= is_status ? status_byte : s_rd[buf_sel];
      tx_loaded <= 1'b1;
    end else if (sck_fall && tx_loaded) begin
      // First bit leaves on the falling edge after the last bit in
      serial_out <= tx[7];                              // see RULE_13
      tx         <= {tx[6:0], 1'b0};
      out_phase  <= 1'b1;
    end
  end

  assign serial_out_oe = selected && out_phase;         // see RULE_08

  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  sfp_pkg::engine_e state;
  sfp_pkg::job_e    job;
  logic             job_buf;
  logic [PW-1:0]    eng_page;
  logic [BW-1:0]    eng_idx;
  logic [TW-1:0]    timer;
  logic [7:0]       flash_mem [PAGES * PAGE_BYTES];     // see RULE_01
  logic [7:0]       flash_rd;

  wire fetch_we = state == sfp_pkg::ST_COPY && job == sfp_pkg::JOB_FETCH;

  // Serial side is never blocked by the engine
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_buf
      page_buffer #(
        .DEPTH (PAGE_BYTES),
        .AW    (BW)
      ) u_buf (
        .sys_clk (sys_clk),
        .s_we    (s_write && buf_sel == 1'(g)),         // see RULE_03
        .s_addr  (s_addr),
        .s_wdata (rx_byte),
        .s_rdata (s_rd[g]),
        .i_we    (fetch_we && job_buf == 1'(g)),
        .i_addr  (eng_idx),
        .i_wdata (flash_rd),
        .i_rdata (i_rd[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Self-timed engine
  // ----------------------------------------------------------------
  wire [PW-1:0] req_page   = addr[`SFP_PAGE_LSB +: PW];
  wire [7:0]    op_kind    = opcode & `SFP_OP_KIND_MASK;
  wire          frame_ok   = cs_rise && byte_idx == 3'h4 && state == sfp_pkg::ST_IDLE;
  wire          want_prog  = frame_ok && op_kind == `SFP_OP_PROGRAM;
  wire          want_fetch = frame_ok && op_kind == `SFP_OP_FETCH;
  wire          prot_hit   = !wp_n_s && req_page < PROT_TOP;
  wire          start_prog = want_prog && !prot_hit;    // see RULE_02
  wire          start      = start_prog || want_fetch;  // see RULE_09
  wire [FW-1:0] flash_addr = FW'(eng_page * PAGE_BYTES + eng_idx);
  wire          copy_end   = eng_idx == LAST_BYTE;

  assign flash_rd    = flash_mem[flash_addr];
  assign status_byte = {ready_busy_flag, refused, 6'h00};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state    <= sfp_pkg::ST_IDLE;                     // see RULE_14
      job      <= sfp_pkg::JOB_PROGRAM;
      job_buf  <= 1'b0;
      eng_page <= '0;
      eng_idx  <= '0;
      timer    <= '0;
      refused  <= 1'b0;
    end else begin
      if (want_prog) begin
        refused <= prot_hit;
      end
      case (state)
        sfp_pkg::ST_IDLE: begin
          if (start) begin
            state    <= sfp_pkg::ST_COPY;
            job      <= start_prog ? sfp_pkg::JOB_PROGRAM : sfp_pkg::JOB_FETCH;
            job_buf  <= opcode[0];
            eng_page <= req_page;
            eng_idx  <= '0;
          end
        end
        sfp_pkg::ST_COPY: begin
          eng_idx <= copy_end ? '0 : BW'(eng_idx + 1'b1);
          if (copy_end) begin
            if (job == sfp_pkg::JOB_PROGRAM) begin
              state <= sfp_pkg::ST_WAIT;
              timer <= TW'(PROG_CYCLES - 1);            // see RULE_06
            end else begin
              state <= sfp_pkg::ST_IDLE;
            end
          end
        end
        sfp_pkg::ST_WAIT: begin
          timer <= timer - 1'b1;
          if (timer == '0) begin
            state <= sfp_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= sfp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Array cells have no reset; a program aborted in ST_COPY leaves the page partial
  always_ff @(posedge sys_clk) begin
    if (state == sfp_pkg::ST_COPY && job == sfp_pkg::JOB_PROGRAM) begin
      flash_mem[flash_addr] <= i_rd[job_buf];
    end
  end

  assign ready_busy_flag = state == sfp_pkg::ST_IDLE;   // see RULE_12

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_deselect_release: assert property ( // see RULE_08
    cs_n_s |-> !serial_out_oe ##1 (!out_phase && !tx_loaded)
  ) else $error("serial_out driven while deselected");

  a_protect_refuse: assert property ( // see RULE_02
    want_prog && prot_hit |=> state == sfp_pkg::ST_IDLE && refused
  ) else $error("protected page program started");

  a_start_on_deselect: assert property ( // see RULE_09
    $rose(state == sfp_pkg::ST_COPY) |-> $past(cs_rise) && $past(byte_idx) == 3'h4
  ) else $error("engine started without deselect");

  a_busy_flag: assert property ( // see RULE_12
    start |=> !ready_busy_flag [*8]
  ) else $error("busy not reported after launch");

  a_word_size: assert property ( // see RULE_10
    $changed(byte_idx) && selected |-> $past(bit_cnt) == 3'h7 && $past(sck_rise)
  ) else $error("byte advanced off an 8-bit boundary");

  a_shift_on_fall: assert property ( // see RULE_13
    $changed(serial_out) |-> $past(sck_fall)
  ) else $error("serial_out changed off a falling edge");

  a_sample_on_rise: assert property ( // see RULE_13
    selected && $past(selected) && $changed(bit_cnt) |-> $past(sck_rise)
  ) else $error("bit sampled off a rising edge");

  a_self_timed: assert property ( // see RULE_06
    $rose(state == sfp_pkg::ST_WAIT) |-> (state == sfp_pkg::ST_WAIT) [*8]
  ) else $error("program wait cut short");

  a_wait_ends: assert property ( // see RULE_06
    state == sfp_pkg::ST_WAIT && timer == '0 |=> state == sfp_pkg::ST_IDLE
  ) else $error("program wait overran");

  a_pointer_range: assert property ( // see RULE_01
    ptr <= LAST_BYTE && eng_idx <= LAST_BYTE
  ) else $error("byte pointer beyond page");

endmodule

// ==== verification/spi_master_model.sv ====
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic sys_clk,          // Paces the link clock
  input  wire logic so_line,          // Resolved serial data line
  output logic      serial_clock,     // Link clock, 200 ns period
  output logic      device_select_n,  // Select, active low
  output logic      serial_in         // Data to device
);
  logic idle_high;  // Mode 3 parks the clock high

  initial begin
    idle_high = 1'b0;
    serial_clock = 1'b0;
    device_select_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic open_frame(input logic mode3);
    idle_high = mode3;
    serial_clock = mode3;
    half();
    device_select_n = 1'b0;
    half();
  endtask

  // Sampled late in the high phase to leave room for the sync lag
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_clock = 1'b0;
      serial_in = tx[i];
      half();
      serial_clock = 1'b1;
      half();
      rx[i] = so_line;
    end
  endtask

  task automatic close_frame();
    serial_clock = idle_high;
    half();
    device_select_n = 1'b1;
    serial_in = ~serial_in;  // Released line never shows the last bit
    half();
  endtask
endmodule

// ==== verification/tb_serial_paged_flash_port.sv ====
`timescale 1ns/1ps
`include "sfp_defines.svh"
module tb_serial_paged_flash_port;
  logic sys_clk, resetn, write_protect_n, serial_clock, device_select_n, serial_in;
  logic serial_out, serial_out_oe, ready_busy_flag;
  logic [7:0] rx;
  int   n_mismatch, check_count;
  // Released line shows the inverse so a missed drive never reads as good data
  wire  so_line = serial_out_oe ? serial_out : ~serial_out;

  // Wait long enough that a two-byte buffer load fits inside one program
  serial_paged_flash_port #(.PROG_CYCLES(200)) serial_paged_flash_port_inst (
    .sys_clk(sys_clk), .resetn(resetn), .serial_clock(serial_clock),
    .device_select_n(device_select_n), .serial_in(serial_in),
    .write_protect_n(write_protect_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .ready_busy_flag(ready_busy_flag));

  spi_master_model spi_master_model_inst (
    .sys_clk(sys_clk), .so_line(so_line), .serial_clock(serial_clock),
    .device_select_n(device_select_n), .serial_in(serial_in));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    check_count++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic head(input logic m3, input logic [7:0] op, input logic [10:0] pg,
                      input logic [8:0] ba);
    logic [23:0] a;
    a = {4'h0, pg, ba};
    spi_master_model_inst.open_frame(m3);
    spi_master_model_inst.xfer(op, rx);
    for (int i = 2; i >= 0; i--) spi_master_model_inst.xfer(a[i*8+:8], rx);
  endtask

  task automatic wr(input logic m3, input logic b, input logic [8:0] ba,
                    input logic [7:0] d[$]);
    head(m3, `SFP_OP_BUF_WRITE | {7'h0, b}, 11'h0, ba);
    foreach (d[i]) spi_master_model_inst.xfer(d[i], rx);
    spi_master_model_inst.close_frame();
  endtask

  task automatic rd(input logic m3, input logic b, input logic [8:0] ba,
                    input logic [7:0] e[$]);
    head(m3, `SFP_OP_BUF_READ | {7'h0, b}, 11'h0, ba);
    foreach (e[i]) begin
      spi_master_model_inst.xfer(8'h00, rx);
      check(rx, e[i]);
    end
    spi_master_model_inst.close_frame();
    check({7'h0, serial_out_oe}, 8'h00);
  endtask

  task automatic launch(input logic [7:0] op, input logic [10:0] pg);
    head(1'b0, op, pg, 9'h000);
    spi_master_model_inst.close_frame();
  endtask

  task automatic wait_rdy(input logic lvl, input int lim);
    for (int i = 0; i < lim && ready_busy_flag !== lvl; i++) @(negedge sys_clk);
  endtask

  task automatic status(input logic [7:0] e);
    spi_master_model_inst.open_frame(1'b1);
    spi_master_model_inst.xfer(`SFP_OP_STATUS, rx);
    spi_master_model_inst.xfer(8'h00, rx);
    spi_master_model_inst.close_frame();
    check(rx, e);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_buffer();
    wr(1'b0, 1'b0, 9'h004, '{8'h11, 8'h22, 8'h33, 8'h44});
    wr(1'b1, 1'b0, 9'h005, '{8'ha5, 8'h5a});
    rd(1'b1, 1'b0, 9'h004, '{8'h11, 8'ha5, 8'h5a, 8'h44});
    wr(1'b1, 1'b0, 9'h107, '{8'hc3, 8'h3c});
    rd(1'b0, 1'b0, 9'h107, '{8'hc3, 8'h3c});
    $display("test buffer done");
  endtask

  task automatic t_program();
    launch(`SFP_OP_PROGRAM, 11'd300);
    wait_rdy(1'b0, 10);
    check({7'h0, ready_busy_flag}, 8'h00);
    wr(1'b0, 1'b1, 9'h000, '{8'h77, 8'h88});
    check({7'h0, ready_busy_flag}, 8'h00);
    wait_rdy(1'b1, 400);
    check({7'h0, ready_busy_flag}, 8'h01);
    rd(1'b0, 1'b1, 9'h000, '{8'h77, 8'h88});
    launch(`SFP_OP_FETCH | 8'h01, 11'd300);
    wait_rdy(1'b0, 10);
    check({7'h0, ready_busy_flag}, 8'h00);
    wait_rdy(1'b1, 400);
    rd(1'b1, 1'b1, 9'h004, '{8'h11, 8'ha5, 8'h5a, 8'h44});
    $display("test program done");
  endtask

  task automatic t_protect();
    write_protect_n = 1'b0;
    launch(`SFP_OP_PROGRAM, 11'd255);
    wait_rdy(1'b0, 20);
    check({7'h0, ready_busy_flag}, 8'h01);
    status((8'h1 << `SFP_ST_READY) | (8'h1 << `SFP_ST_REFUSED));
    launch(`SFP_OP_PROGRAM, 11'd256);
    wait_rdy(1'b0, 10);
    check({7'h0, ready_busy_flag}, 8'h00);
    wait_rdy(1'b1, 600);
    status(8'h1 << `SFP_ST_READY);
    write_protect_n = 1'b1;
    $display("test protect done");
  endtask

  task automatic t_reset_mid();
    launch(`SFP_OP_PROGRAM, 11'd400);
    wait_rdy(1'b0, 10);
    resetn = 1'b0;
    @(negedge sys_clk);
    check({7'h0, ready_busy_flag}, 8'h01);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    status(8'h1 << `SFP_ST_READY);
    rd(1'b0, 1'b0, 9'h004, '{8'h11, 8'ha5, 8'h5a, 8'h44});
    $display("test reset done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    write_protect_n = 1'b1;
    repeat (16) @(negedge sys_clk);
    check({6'h0, serial_out_oe, ready_busy_flag}, 8'h01);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_buffer();
    t_program();
    t_protect();
    t_reset_mid();
    finish_test();
  end

  // Whole run needs roughly 7k cycles; this is a wide margin
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
endmodule
